// ---- include/sensor_map_pkg.sv ----
/*
 Shared constants, carriers and the CRC step for the sensor data array map.
 Assumes one 8-bit register per byte address, 5-bit addresses.
*/
`default_nettype none

package sensor_map_pkg;

	// geometry
	localparam int OTP_BYTES   = 9;
	localparam int OTP_AW      = 4;
	localparam int ADDR_W      = 5;
	localparam int SERIAL_W    = 13;

	// byte addresses
	localparam logic [4:0] ADDR_TRACE0   = 5'h00;
	localparam logic [4:0] ADDR_TRACE3   = 5'h03;
	localparam logic [4:0] ADDR_RSVD_A   = 5'h04;
	localparam logic [4:0] ADDR_RSVD_B   = 5'h05;
	localparam logic [4:0] ADDR_FACTCFG  = 5'h06;
	localparam logic [4:0] ADDR_PARTCODE = 5'h08;
	localparam logic [4:0] ADDR_RSTCTL   = 5'h0a;
	localparam logic [4:0] ADDR_DEVICE_CONFIG   = 5'h0b;
	localparam logic [4:0] ADDR_AXISCFG  = 5'h0c;
	localparam logic [4:0] ADDR_ARMING_CONFIG   = 5'h0e;
	localparam logic [4:0] ADDR_ARMT_POS = 5'h10;
	localparam logic [4:0] ADDR_ARMT_NEG = 5'h12;
	localparam logic [4:0] ADDR_DEVICE_STATUS  = 5'h14;
	localparam logic [4:0] ADDR_TALLY    = 5'h15;
	localparam logic [4:0] ADDR_OFFCORR  = 5'h16;
	localparam logic [4:0] ADDR_RSVD_HA  = 5'h1c;
	localparam logic [4:0] ADDR_RSVD_HB  = 5'h1d;

	// fields and reset values
	localparam int         ENDINIT_BIT = 5;
	localparam logic [7:0] RW_RESET    = 8'h00;
	localparam logic [7:0] RSVD_HIGH   = 8'h00;
	localparam logic [7:0] CRC_POLY    = 8'h2f;
	localparam logic [7:0] CRC_SEED    = 8'hff;

	typedef logic [OTP_BYTES-1:0][7:0] otp_image_t;

	typedef struct packed {
		logic [18:0] lot_index;
		logic [12:0] per_lot_unit_index;
	} trace_s;

	typedef struct packed {
		logic [7:0] device_status;
		logic [7:0] arm_event_tally;
		logic [7:0] offset_correction_value;
	} status_s;

	typedef struct packed {
		logic [7:0] reset_control;
		logic [7:0] device_config;
		logic [7:0] axis_filter_config;
		logic [7:0] arming_config;
		logic [7:0] arming_threshold_pos;
		logic [7:0] arming_threshold_neg;
	} cfg_s;

	typedef enum {SRC_OTP, SRC_REG, SRC_BAD} src_e;

	// one byte through a msb-first crc-8
	function automatic logic [7:0] crc8_step(input logic [7:0] crc,
	                                         input logic [7:0] data,
	                                         input logic [7:0] poly);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ poly) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8_step

endpackage : sensor_map_pkg

`default_nettype wire

// ---- sim/host_access_model.sv ----
/*
 Host side model: issues one register access at a time and waits for
 its answer. Assumes answers arrive a few cycles after the request.
*/
`timescale 1ns/1ps
`default_nettype none

module host_access_model (
	// clock
	input  wire logic       core_clk_in,
	// request
	output logic            acc_req_out,
	output logic            acc_write_out,
	output logic [4:0]      acc_addr_out,
	output logic [7:0]      acc_wdata_out,
	// answer
	input  wire logic       resp_valid_in,
	input  wire logic       resp_invalid_in,
	input  wire logic [7:0] resp_data_in
);

	initial begin
		acc_req_out   = 1'b0;
		acc_write_out = 1'b0;
		acc_addr_out  = 5'h00;
		acc_wdata_out = 8'h00;
	end

	// got stays low when no answer comes within the window
	task automatic access(input logic w, input logic [4:0] a,
		input logic [7:0] d, output logic inv, output logic [7:0] rd,
		output logic got);
		got = 1'b0;
		inv = 1'b1;
		rd  = 8'h00;
		@(posedge core_clk_in);
		acc_req_out   <= 1'b1;
		acc_write_out <= w;
		acc_addr_out  <= a;
		acc_wdata_out <= d; // callers may set reserved bits, e.g. 8'hff to 0x1c
		@(posedge core_clk_in);
		acc_req_out   <= 1'b0;
		// released lines show junk, not the last value
		acc_addr_out  <= ~a;
		acc_wdata_out <= ~d;
		for (int k = 0; k < 6 && !got; k++) begin
			@(posedge core_clk_in);
			if (resp_valid_in === 1'b1) begin
				got = 1'b1;
				inv = resp_invalid_in;
				rd  = resp_data_in;
			end
		end
	endtask : access

endmodule : host_access_model

`default_nettype wire

// ---- sim/sensor_data_array_map_bench.sv ----
/*
 Self-checking bench for the sensor data array map.
 Assumes the host model and the design package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module sensor_data_array_map_bench;

	// design signals
	logic                       core_clk_in;
	logic                       rstn_in;
	sensor_map_pkg::otp_image_t image;
	logic [7:0]                 crc;
	sensor_map_pkg::status_s    status;
	logic                       req;
	logic                       wr;
	logic [4:0]                 addr;
	logic [7:0]                 wdata;
	logic                       rv;
	logic                       rinv;
	logic [7:0]                 rdata;
	logic                       ready;
	sensor_map_pkg::cfg_s       cfg;
	logic                       lock;
	logic                       ofault;
	logic                       wfault;
	int                         n_errors;
	int                         num_checks;
	// trace code 0x00123456 in bytes 0..3
	localparam sensor_map_pkg::otp_image_t IMG = {8'h35, 8'h77, 8'h80,
		8'h22, 8'h11, 8'h00, 8'h12, 8'h34, 8'h56};

	sensor_data_array_map i_sensor_data_array_map (
		.core_clk_in       (core_clk_in),
		.rstn_in           (rstn_in),
		.otp_image_in      (image),
		.otp_crc_in        (crc),
		.acc_req_in        (req),
		.acc_write_in      (wr),
		.acc_addr_in       (addr),
		.acc_wdata_in      (wdata),
		.status_in         (status),
		.resp_valid_out    (rv),
		.resp_invalid_out  (rinv),
		.resp_data_out     (rdata),
		.ready_out         (ready),
		.cfg_out           (cfg),
		.lock_out          (lock),
		.otp_crc_fault_out (ofault),
		.wr_crc_fault_out  (wfault)
	);

	host_access_model i_host_access_model (
		.core_clk_in     (core_clk_in),
		.acc_req_out     (req),
		.acc_write_out   (wr),
		.acc_addr_out    (addr),
		.acc_wdata_out   (wdata),
		.resp_valid_in   (rv),
		.resp_invalid_in (rinv),
		.resp_data_in    (rdata)
	);

	initial begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end

	// own crc, kept apart from the design's function
	function automatic logic [7:0] crc_of(
		input sensor_map_pkg::otp_image_t img);
		logic [7:0] c;
		c = sensor_map_pkg::CRC_SEED;
		for (int b = 0; b < 9; b++) begin
			c = c ^ img[b];
			for (int k = 0; k < 8; k++) begin
				c = {c[6:0], 1'b0} ^ (c[7] ? sensor_map_pkg::CRC_POLY : 8'h00);
			end
		end
		return c;
	endfunction : crc_of

	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results

	task automatic acc(input logic w, input logic [4:0] a,
		input logic [7:0] d, input logic ei, input logic [7:0] ed);
		logic       i;
		logic [7:0] r;
		logic       g;
		i_host_access_model.access(w, a, d, i, r, g);
		#1;
		if (g !== 1'b1) begin
			n_errors++;
			$display("MISMATCH at %0t got %h exp %h", $time, g, 1'b1);
			results();
		end else begin
			check({39'h0, i, r}, {39'h0, ei, ed});
		end
	endtask : acc

	// a request in reset and one during fill must both go unanswered
	task automatic restart(input sensor_map_pkg::otp_image_t img,
		input logic [7:0] c, input logic ef);
		logic       i;
		logic [7:0] r;
		logic       g;
		@(posedge core_clk_in);
		rstn_in <= 1'b0;
		image   <= img;
		crc     <= c;
		i_host_access_model.access(1'b0, 5'h00, 8'h00, i, r, g);
		#1;
		check({43'h0, g, ready, lock, ofault, wfault}, 48'h0);
		check(cfg, 48'h0);
		@(posedge core_clk_in);
		rstn_in <= 1'b1;
		i_host_access_model.access(1'b0, 5'h00, 8'h00, i, r, g);
		@(posedge core_clk_in);
		#1;
		check({46'h0, g, ready}, 48'h0);
		@(posedge core_clk_in);
		#1;
		check({45'h0, ready, ofault, wfault}, {45'h0, 1'b1, ef, 1'b0});
	endtask : restart

	task automatic t_factory();
		sensor_map_pkg::trace_s t;
		for (int a = 0; a < 9; a++) begin
			if (a != 7) begin
				acc(1'b0, a[4:0], 8'h00, 1'b0, IMG[a]);
				acc(1'b1, a[4:0], ~IMG[a], 1'b0, IMG[a]);
				acc(1'b0, a[4:0], 8'h00, 1'b0, IMG[a]);
			end
		end
		t = IMG[3:0];
		check({35'h0, t.per_lot_unit_index}, 48'h1456);
		check({29'h0, t.lot_index}, 48'h0091);
		$display("test factory done");
	endtask : t_factory

	task automatic t_holes();
		logic [4:0] h [11] = '{5'h07, 5'h09, 5'h0d, 5'h0f, 5'h11, 5'h13,
			5'h17, 5'h18, 5'h1b, 5'h1e, 5'h1f};
		foreach (h[i]) begin
			acc(1'b0, h[i], 8'h00, 1'b1, 8'h00);
			acc(1'b1, h[i], 8'h5a, 1'b1, 8'h00);
		end
		$display("test holes done");
	endtask : t_holes

	task automatic t_rw();
		logic [4:0] ra [6] = '{5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h10, 5'h12};
		logic [7:0] v [6] = '{8'h80, 8'h15, 8'h8a, 8'h2d, 8'ha5, 8'h5a};
		foreach (ra[i]) acc(1'b1, ra[i], v[i], 1'b0, 8'h00);
		foreach (ra[i]) acc(1'b0, ra[i], 8'h00, 1'b0, v[i]);
		check(cfg, 48'h8015_8a2d_a55a);
		@(posedge core_clk_in);
		status <= 24'hc3_7e19;
		acc(1'b0, 5'h14, 8'h00, 1'b0, 8'hc3);
		acc(1'b1, 5'h15, 8'h00, 1'b0, 8'h7e);
		acc(1'b0, 5'h16, 8'h00, 1'b0, 8'h19);
		acc(1'b0, 5'h15, 8'h00, 1'b0, 8'h7e);
		acc(1'b1, 5'h1c, 8'hff, 1'b0, sensor_map_pkg::RSVD_HIGH);
		acc(1'b0, 5'h1c, 8'h00, 1'b0, sensor_map_pkg::RSVD_HIGH);
		acc(1'b0, 5'h1d, 8'h00, 1'b0, sensor_map_pkg::RSVD_HIGH);
		$display("test read write done");
	endtask : t_rw

	// after the lock only the reset control byte still takes writes
	task automatic t_lock();
		acc(1'b1, 5'h0b, 8'h35, 1'b0, 8'h15);
		check({47'h0, lock}, 48'h1);
		acc(1'b1, 5'h10, 8'h00, 1'b0, 8'ha5);
		acc(1'b1, 5'h0b, 8'h15, 1'b0, 8'h35);
		acc(1'b1, 5'h0a, 8'h00, 1'b0, 8'h80);
		acc(1'b0, 5'h0a, 8'h00, 1'b0, 8'h00);
		check(cfg, 48'h0035_8a2d_a55a);
		check({47'h0, wfault}, 48'h0);
		$display("test lock done");
	endtask : t_lock

	task automatic t_crc();
		sensor_map_pkg::otp_image_t img;
		restart(IMG, crc_of(IMG) ^ 8'h01, 1'b1);
		img = IMG;
		img[0] = 8'h57;
		restart(img, crc_of(IMG), 1'b1);
		img[3] = 8'hf0;
		restart(img, crc_of(img), 1'b0);
		check({47'h0, lock}, 48'h0);
		check(cfg, 48'h0);
		acc(1'b0, 5'h00, 8'h00, 1'b0, 8'h57);
		$display("test crc done");
	endtask : t_crc

	initial begin
		n_errors   = 0;
		num_checks = 0;
		rstn_in    = 1'b0;
		image      = IMG;
		crc        = 8'h00;
		status     = 24'h0;
		restart(IMG, crc_of(IMG), 1'b0);
		t_factory();
		t_holes();
		t_rw();
		t_lock();
		t_crc();
		results();
	end

endmodule : sensor_data_array_map_bench

`default_nettype wire

// ---- src/otp_shadow_mem.sv ----
/*
 Small shadow memory for the factory block: one write port, one read port
 with registered read data. Assumes a single clock and async low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module otp_shadow_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 9,
	parameter int AW    = 4
) (
	// clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             rstn_in,
	// fill port
	input  wire logic             wr_en_in,
	input  wire logic [AW-1:0]    wr_addr_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	// read port
	input  wire logic [AW-1:0]    rd_addr_in,
	output logic      [WIDTH-1:0] rd_data_out
);

	if (DEPTH < 1 || DEPTH > (1 << AW) || WIDTH < 1) begin : g_bad_geom
		$error("otp_shadow_mem: bad geometry");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge core_clk_in) begin
		if (wr_en_in && int'(wr_addr_in) < DEPTH)
			mem[wr_addr_in] <= wr_data_in;
	end

	// out-of-range reads give zero, never stale data
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			rd_data_out <= '0;
		else if (int'(rd_addr_in) < DEPTH)
			rd_data_out <= mem[rd_addr_in];
		else
			rd_data_out <= '0;
	end

endmodule : otp_shadow_mem

`default_nettype wire

// ---- src/sensor_data_array_map.sv ----
/*
 Customer data array: factory shadow block, writable configuration with
 lock, read-only status, two crc checkers and a register access port.
 Assumes the serial front end hands over decoded accesses synchronous to
 core_clk_in and that the factory image is stable from reset release.
*/
// What this block does
// - the array is a factory read-only section plus host read/write config and status registers.
// - the factory section and the writable section each have their own crc checker and fault flag.
// - a lock, once set, blocks further writes to the writable section except reset control in normal operation.
// - bytes 0x00 to 0x08 except the hole at 0x07 are factory storage the host may read but never alter.
// - a 32-bit unit trace code sits in bytes 0x00 (low) to 0x03 (high).
// - the low 13 bits of the trace code are the per-lot unit index, bits 31 to 13 the lot index.
// - the four trace bytes are included in the crc over the factory shadow copy.
// - the trace bytes affect nothing except crc and readout.
// - bytes 0x04 and 0x05 are reserved, read-only and without effect.
`timescale 1ns/1ps
`default_nettype none

module sensor_data_array_map #(
	parameter logic [7:0] CRC_POLY = sensor_map_pkg::CRC_POLY
) (
	// clock and reset
	input  wire logic                       core_clk_in,
	input  wire logic                       rstn_in,
	// factory image and its stored crc
	input  wire sensor_map_pkg::otp_image_t otp_image_in,
	input  wire logic [7:0]                 otp_crc_in,
	// register access
	input  wire logic                       acc_req_in,
	input  wire logic                       acc_write_in,
	input  wire logic [4:0]                 acc_addr_in,
	input  wire logic [7:0]                 acc_wdata_in,
	// status from the measurement path
	input  wire sensor_map_pkg::status_s    status_in,
	// answers
	output logic                            resp_valid_out,
	output logic                            resp_invalid_out,
	output logic [7:0]                      resp_data_out,
	// configuration and health
	output logic                            ready_out,
	output sensor_map_pkg::cfg_s            cfg_out,
	output logic                            lock_out,
	output logic                            otp_crc_fault_out,
	output logic                            wr_crc_fault_out
);

	// refused at elaboration; a zero polynomial gives a crc of zero whatever the data
	if (CRC_POLY == 8'h00) begin : g_zero_poly
		$error("sensor_data_array_map: crc polynomial is zero");
	end

	typedef enum {LD_FILL, LD_CHECK, LD_RUN} load_e;

	load_e                 load_state;
	logic [3:0]            load_idx;
	logic [7:0]            otp_crc_acc;
	logic                  take;
	logic                  wr_en;
	logic [7:0]            mem_rd;
	sensor_map_pkg::src_e  next_src;
	sensor_map_pkg::src_e  s1_src;
	logic [7:0]            next_reg_rd;
	logic [7:0]            s1_reg_rd;
	logic                  s1_valid;
	logic                  is_otp;
	logic                  lock;
	logic                  lock_q;
	logic [7:0]            wr_crc_now;
	logic [7:0]            wr_crc_snap;
	sensor_map_pkg::trace_s trace;

	assign take  = acc_req_in && (load_state == LD_RUN);
	assign wr_en = (load_state == LD_FILL);
	assign lock  = cfg_out.device_config[sensor_map_pkg::ENDINIT_BIT];

	// trace code split for traceability readout only
	assign trace = sensor_map_pkg::trace_s'({otp_image_in[3], otp_image_in[2],
	                                         otp_image_in[1], otp_image_in[0]});

	// factory shadow copy, filled once after reset
	otp_shadow_mem #(
		.WIDTH (8),
		.DEPTH (sensor_map_pkg::OTP_BYTES),
		.AW    (sensor_map_pkg::OTP_AW)
	) u_shadow (
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.wr_en_in    (wr_en),
		.wr_addr_in  (load_idx),
		.wr_data_in  (otp_image_in[load_idx]),
		.rd_addr_in  (acc_addr_in[3:0]),
		.rd_data_out (mem_rd)
	);

	// fill sequence; image caught by clock after release, not at reset
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			load_state <= LD_FILL;
			load_idx   <= 4'h0;
		end else begin
			case (load_state)
				// index parks on the last byte, never past the image
				LD_FILL: begin
					if (int'(load_idx) == sensor_map_pkg::OTP_BYTES - 1)
						load_state <= LD_CHECK;
					else
						load_idx <= load_idx + 4'h1;
				end
				LD_CHECK: load_state <= LD_RUN;
				LD_RUN:   load_state <= LD_RUN;
				default:  load_state <= LD_FILL;
			endcase
		end
	end

	// factory crc covers every shadow byte, trace bytes included
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			otp_crc_acc <= sensor_map_pkg::CRC_SEED;
		else if (load_state == LD_FILL)
			otp_crc_acc <= sensor_map_pkg::crc8_step(otp_crc_acc,
			                   otp_image_in[load_idx], CRC_POLY);
	end

	// sticky until the next reset
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			otp_crc_fault_out <= 1'b0;
		else if (load_state == LD_CHECK && otp_crc_acc != otp_crc_in)
			otp_crc_fault_out <= 1'b1;
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			ready_out <= 1'b0;
		else
			ready_out <= (load_state == LD_CHECK) || (load_state == LD_RUN);
	end

	// writable section; reserved bits stored as written
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_out <= {6{sensor_map_pkg::RW_RESET}};
		end else if (take && acc_write_in) begin
			// reset control stays writable under the lock
			if (acc_addr_in == sensor_map_pkg::ADDR_RSTCTL)
				cfg_out.reset_control <= acc_wdata_in;
			if (!lock) begin
				case (acc_addr_in)
					sensor_map_pkg::ADDR_DEVICE_CONFIG:
						cfg_out.device_config <= acc_wdata_in;
					sensor_map_pkg::ADDR_AXISCFG:
						cfg_out.axis_filter_config <= acc_wdata_in;
					sensor_map_pkg::ADDR_ARMING_CONFIG:
						cfg_out.arming_config <= acc_wdata_in;
					sensor_map_pkg::ADDR_ARMT_POS:
						cfg_out.arming_threshold_pos <= acc_wdata_in;
					sensor_map_pkg::ADDR_ARMT_NEG:
						cfg_out.arming_threshold_neg <= acc_wdata_in;
					// factory, status and reserved writes dropped
					// empty so the reset control write above survives
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lock_q   <= 1'b0;
			lock_out <= 1'b0;
		end else begin
			lock_q   <= lock;
			lock_out <= lock;
		end
	end

	// writable crc over the locked bytes; reset control left out on purpose
	always_comb begin
		wr_crc_now = sensor_map_pkg::CRC_SEED;
		wr_crc_now = sensor_map_pkg::crc8_step(wr_crc_now,
		                 cfg_out.device_config, CRC_POLY);
		wr_crc_now = sensor_map_pkg::crc8_step(wr_crc_now,
		                 cfg_out.axis_filter_config, CRC_POLY);
		wr_crc_now = sensor_map_pkg::crc8_step(wr_crc_now,
		                 cfg_out.arming_config, CRC_POLY);
		wr_crc_now = sensor_map_pkg::crc8_step(wr_crc_now,
		                 cfg_out.arming_threshold_pos, CRC_POLY);
		wr_crc_now = sensor_map_pkg::crc8_step(wr_crc_now,
		                 cfg_out.arming_threshold_neg, CRC_POLY);
	end

	// snapshot at lock; checking only runs once locked
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			wr_crc_snap <= sensor_map_pkg::CRC_SEED;
		else if (lock && !lock_q)
			wr_crc_snap <= wr_crc_now;
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			wr_crc_fault_out <= 1'b0;
		else if (lock_q && wr_crc_now != wr_crc_snap)
			wr_crc_fault_out <= 1'b1;
	end

	// factory addresses; 0x07 is a hole
	assign is_otp = (acc_addr_in <= sensor_map_pkg::ADDR_PARTCODE) &&
	                (acc_addr_in != 5'h07);

	// decode: trace bytes only ever reach readout and crc
	always_comb begin
		next_src    = sensor_map_pkg::SRC_REG;
		next_reg_rd = 8'h00;
		if (is_otp) begin
			next_src = sensor_map_pkg::SRC_OTP;
		end else begin
			case (acc_addr_in)
				sensor_map_pkg::ADDR_RSTCTL:
					next_reg_rd = cfg_out.reset_control;
				sensor_map_pkg::ADDR_DEVICE_CONFIG:
					next_reg_rd = cfg_out.device_config;
				sensor_map_pkg::ADDR_AXISCFG:
					next_reg_rd = cfg_out.axis_filter_config;
				sensor_map_pkg::ADDR_ARMING_CONFIG:
					next_reg_rd = cfg_out.arming_config;
				sensor_map_pkg::ADDR_ARMT_POS:
					next_reg_rd = cfg_out.arming_threshold_pos;
				sensor_map_pkg::ADDR_ARMT_NEG:
					next_reg_rd = cfg_out.arming_threshold_neg;
				sensor_map_pkg::ADDR_DEVICE_STATUS:
					next_reg_rd = status_in.device_status;
				sensor_map_pkg::ADDR_TALLY:
					next_reg_rd = status_in.arm_event_tally;
				sensor_map_pkg::ADDR_OFFCORR:
					next_reg_rd = status_in.offset_correction_value;
				sensor_map_pkg::ADDR_RSVD_HA,
				sensor_map_pkg::ADDR_RSVD_HB:
					next_reg_rd = sensor_map_pkg::RSVD_HIGH;
				default:
					next_src = sensor_map_pkg::SRC_BAD;
			endcase
		end
	end

	// stage one lines up with the registered shadow read
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_valid  <= 1'b0;
			s1_src    <= sensor_map_pkg::SRC_BAD;
			s1_reg_rd <= 8'h00;
		end else begin
			s1_valid  <= take;
			s1_src    <= next_src;
			s1_reg_rd <= next_reg_rd;
		end
	end

	// answer two edges after the request; writes echo the old value
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			resp_valid_out   <= 1'b0;
			resp_invalid_out <= 1'b0;
			resp_data_out    <= 8'h00;
		end else begin
			resp_valid_out   <= s1_valid;
			resp_invalid_out <= s1_valid &&
			                    (s1_src == sensor_map_pkg::SRC_BAD);
			case (s1_src)
				sensor_map_pkg::SRC_OTP: resp_data_out <= mem_rd;
				sensor_map_pkg::SRC_REG: resp_data_out <= s1_reg_rd;
				default:                 resp_data_out <= 8'h00;
			endcase
		end
	end

	chk_bad_addr_answer: assert property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		take && acc_addr_in == 5'h07 |-> ##2 resp_valid_out && resp_invalid_out
	) else $error("hole address did not get invalid answer");

	chk_trace_low_read: assert property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		take && !acc_write_in && acc_addr_in == sensor_map_pkg::ADDR_TRACE0
		|-> ##2 resp_data_out == otp_image_in[0] && !resp_invalid_out
	) else $error("trace byte 0 read wrong");

	chk_unit_index_hi: assert property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		take && !acc_write_in && acc_addr_in == 5'h01
		|-> ##2 resp_data_out[4:0] == trace.per_lot_unit_index[12:8]
	) else $error("unit index bits misplaced");

	chk_reserved_read: assert property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		take && !acc_write_in && acc_addr_in == sensor_map_pkg::ADDR_RSVD_B
		|-> ##2 resp_data_out == otp_image_in[5]
	) else $error("reserved byte read wrong");

	chk_ro_write_ignored: assert property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		take && acc_write_in && (is_otp ||
		acc_addr_in == sensor_map_pkg::ADDR_DEVICE_STATUS) |=> $stable(cfg_out)
	) else $error("read-only write changed config");

	chk_lock_blocks_cfg: assert property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		lock && take && acc_write_in |=>
		$stable(cfg_out.arming_threshold_pos) && $stable(cfg_out.device_config)
	) else $error("locked config changed");

	chk_lock_sticky: assert property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		lock_out |=> lock_out [*3]
	) else $error("lock dropped");

	chk_rw_write_lands: assert property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		!lock && take && acc_write_in &&
		acc_addr_in == sensor_map_pkg::ADDR_ARMT_POS
		|=> cfg_out.arming_threshold_pos == $past(acc_wdata_in)
	) else $error("unlocked write lost");

	chk_otp_crc_flag: assert property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		load_state == LD_CHECK |=>
		otp_crc_fault_out == ($past(otp_crc_acc) != $past(otp_crc_in))
	) else $error("factory crc flag wrong");

	chk_wr_crc_flag: assert property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		lock_q && wr_crc_now != wr_crc_snap |=> wr_crc_fault_out
	) else $error("writable crc fault missed");

	cov_locked: cover property (
		@(posedge core_clk_in) disable iff (!rstn_in) lock && !lock_q);
	cov_bad_access: cover property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		resp_valid_out && resp_invalid_out);
	cov_otp_read: cover property (
		@(posedge core_clk_in) disable iff (!rstn_in)
		take && !acc_write_in && is_otp ##2 resp_valid_out);

endmodule : sensor_data_array_map

`default_nettype wire
